/* File: core/tecfd_pkg.sv */
package tecfd_pkg;
  localparam int DATA_W = 8;

  // Register indices on the plain register port
  localparam logic [3:0] ADDR_CNT0_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_CNT0_PRE   = 4'h1;
  localparam logic [3:0] ADDR_CNT0_VAL   = 4'h2;
  localparam logic [3:0] ADDR_CNT1_CTRL  = 4'h3;
  localparam logic [3:0] ADDR_CNT1_PRE   = 4'h4;
  localparam logic [3:0] ADDR_CNT1_VAL   = 4'h5;
  localparam logic [3:0] ADDR_IRQ_CTRL   = 4'h6;
  localparam logic [3:0] ADDR_MISC_CTRL  = 4'h7;
  localparam logic [3:0] ADDR_PORT_DIR   = 4'h8;
  localparam logic [3:0] ADDR_PORT_DATA  = 4'h9;
  localparam logic [3:0] ADDR_PWR_CTRL   = 4'ha;

  // Counter control fields
  localparam int CTL_MODE_HI = 7;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_RUN     = 4;
  localparam int CTL_EDGE    = 3;
  localparam int CTL_PSC_HI  = 2;
  localparam int CTL_PSC_LO  = 0;

  // Interrupt control fields
  localparam int IRQ_EN0   = 2;
  localparam int IRQ_EN1   = 3;
  localparam int IRQ_FLAG0 = 5;
  localparam int IRQ_FLAG1 = 6;

  // Misc function control fields
  localparam int MISC_DIV_EN  = 0;
  localparam int MISC_DIV_SEL = 1;

  // Port bit shared with the divider output
  localparam int DIV_PIN_BIT = 1;

  localparam logic [7:0] VECTOR_CNT0 = 8'h08;
  localparam logic [7:0] VECTOR_CNT1 = 8'h0c;

  typedef enum logic [1:0] {
    TECFD_MODE_OFF   = 2'b00,
    TECFD_MODE_EVENT = 2'b01,
    TECFD_MODE_TIMER = 2'b10,
    TECFD_MODE_PULSE = 2'b11
  } tecfd_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } tecfd_req_t;

  typedef struct packed {
    logic       irq_req;
    logic [7:0] irq_vector;
    logic       wake;
  } tecfd_evt_t;
endpackage : tecfd_pkg

/* File: core/tecfd_counter.sv */
`timescale 1ns/10ps
module tecfd_counter
  import tecfd_pkg::*;
#(
  parameter int  WIDTH   = 8,
  parameter bit  HAS_PSC = 1'b1
) (
  input  wire logic             core_clk,
  input  wire logic             rstn,
  input  wire logic [7:0]       ctrl,
  input  wire logic [WIDTH-1:0] preload,
  input  wire logic             preload_wr,
  input  wire logic             inhibit,
  input  wire logic             ext_pin,
  output logic      [WIDTH-1:0] count_q,
  output logic                  ovf,
  output logic                  run_clear
);
  import tecfd_pkg::*;

  tecfd_mode_t mode;
  logic        run;
  logic        edge_sel;
  logic [2:0]  psc_sel;
  logic [6:0]  psc_q;
  logic        tick;
  logic        pin_q;
  logic        active_edge;
  logic        return_edge;
  logic        pulse_start;
  logic        pulse_on_q;
  logic        step;

  assign mode     = tecfd_mode_t'(ctrl[CTL_MODE_HI:CTL_MODE_LO]);
  assign run      = ctrl[CTL_RUN];
  assign edge_sel = ctrl[CTL_EDGE];
  assign psc_sel  = ctrl[CTL_PSC_HI:CTL_PSC_LO];

  // Free-running prescaler; code n divides by 2**n
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      psc_q <= '0;
    end else begin
      psc_q <= psc_q + 7'h01;
    end
  end

  always_comb begin
    tick = 1'b1;
    if (HAS_PSC && psc_sel != 3'h0) begin  // [RL8] [RL24] [RL3]
      tick = &psc_q[psc_sel-3'h1 -: 1] && ((psc_q & ((7'h01 << psc_sel) - 7'h01)) == ((7'h01 << psc_sel) - 7'h01));
    end
  end

  // Pin seen only on the next timer tick, so up to one tick of error
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      // Idle level of the pulled-high pin, so no false edge follows reset
      pin_q <= 1'b1;
    end else if (tick) begin
      pin_q <= ext_pin;  // [RL11]
    end
  end

  assign active_edge = tick && (edge_sel ? (pin_q && !ext_pin) : (!pin_q && ext_pin));  // [RL22]
  // With bit 3 low pulse mode starts on the edge that leaves the idle level and ends on the way back; bit 3 high swaps the two edges
  assign pulse_start = tick && (edge_sel ? (!pin_q && ext_pin) : (pin_q && !ext_pin));  // [RL23]
  assign return_edge = tick && (edge_sel ? (pin_q && !ext_pin) : (!pin_q && ext_pin));

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pulse_on_q <= 1'b0;
    end else if (!run || mode != TECFD_MODE_PULSE) begin
      pulse_on_q <= 1'b0;
    end else if (!pulse_on_q && pulse_start) begin
      pulse_on_q <= 1'b1;  // [RL23]
    end else if (pulse_on_q && return_edge) begin
      pulse_on_q <= 1'b0;
    end
  end

  assign run_clear = (mode == TECFD_MODE_PULSE) && run && pulse_on_q && return_edge;  // [RL23]

  always_comb begin
    step = 1'b0;
    unique case (mode)
      TECFD_MODE_OFF:   step = 1'b0;
      TECFD_MODE_TIMER: step = tick;
      TECFD_MODE_EVENT: step = active_edge;  // [RL10]
      TECFD_MODE_PULSE: step = tick && pulse_on_q && !return_edge;
    endcase
    if (!run || inhibit) begin
      step = 1'b0;  // [RL18] [RL14]
    end
  end

  assign ovf = step && (&count_q);

  // Contents after power-on are not defined; software preloads first
  always_ff @(posedge core_clk) begin
    if (preload_wr && !run) begin
      count_q <= preload;
    end else if (ovf) begin
      count_q <= preload;  // [RL2]
    end else if (step) begin
      count_q <= count_q + 1'b1;  // [RL1]
    end
  end
endmodule : tecfd_counter

/* File: core/tecfd_top.sv */
`timescale 1ns/10ps
// Behaviour
// RL1 - Each counter is eight bits and counts up from the preload value.
// RL2 - On passing full scale: overflow, reload from preload, continue counting.
// RL3 - Count advances on system clock divided by the prescaler where present.
// RL4 - Divider output toggles on every overflow of the selected counter.
// RL5 - Misc control enables divider and picks counter; else pin is plain I/O.
// RL6 - Divider reaches pin only when port direction bit 1 is output.
// RL7 - Port data bit 1 gates divider: one passes wave, zero holds low.
// RL8 - Three-bit field in counter 0 control selects its clock division.
// RL9 - Counter 1 has no prescaler; its clock feeds it directly.
// RL10 - Event or pulse mode needs mode bits set and pin as input.
// RL11 - Pin changes are acted on only at the next timer tick.
// RL12 - Overflow in timer mode raises an interrupt with its own vector.
// RL13 - Counter 0 overflow vector is address 08h.
// RL14 - Counter reads and preload writes suspend counting for that cycle.
// RL15 - Overflow sets request flag; interrupt only when enable bit set.
// RL16 - Disabled counter never interrupts, though its flag may be set.
// RL17 - Software loads a preload value before starting a counter.
// RL18 - Control bit 4 starts and stops the counter.
// RL19 - Overflow during power-down wakes device regardless of interrupt enable.
// RL20 - Flag already set at power-down blocks wake on later overflow.
// RL21 - Control bits 7:6 select mode: 10 timer, 01 event, 11 pulse.
// RL22 - Control bit 3 low counts rising edges, high counts falling edges.
// RL23 - Pulse mode runs between edges then clears run bit itself.
// RL24 - Prescaler code is a power-of-two exponent; 001 divides by two.
module tecfd_top
  import tecfd_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rstn,
  input  wire tecfd_pkg::tecfd_req_t req,
  output logic      [7:0]           rdata,
  input  wire logic                 ext_pin0,
  input  wire logic                 ext_pin1,
  input  wire logic [7:0]           port_in,
  output logic      [7:0]           port_out,
  output logic      [7:0]           port_oe,
  output tecfd_pkg::tecfd_evt_t     evt
);
  import tecfd_pkg::*;

  logic [7:0] cnt0_ctrl_q;
  logic [7:0] cnt1_ctrl_q;
  logic [7:0] cnt0_pre_q;
  logic [7:0] cnt1_pre_q;
  logic [7:0] irq_ctrl_q;
  logic [7:0] misc_q;
  logic [7:0] port_dir_q;
  logic [7:0] port_data_q;
  logic       pwr_down_q;
  logic       tone_q;
  logic [7:0] cnt0_val;
  logic [7:0] cnt1_val;
  logic       ovf0;
  logic       ovf1;
  logic       clr0;
  logic       clr1;
  logic       inh0;
  logic       inh1;
  logic       wr0_pre;
  logic       wr1_pre;
  logic       sel_ovf;
  logic       div_on_pin;
  logic       irq0;
  logic       irq1;
  logic [7:0] pre0_src;
  logic [7:0] pre1_src;

  assign wr0_pre = req.wr && req.addr == ADDR_CNT0_PRE;
  assign wr1_pre = req.wr && req.addr == ADDR_CNT1_PRE;
  assign inh0    = wr0_pre || (req.rd && req.addr == ADDR_CNT0_VAL);  // [RL14]
  assign inh1    = wr1_pre || (req.rd && req.addr == ADDR_CNT1_VAL);  // [RL14]

  // A stopped counter takes the value being written, not the stale preload
  assign pre0_src = wr0_pre ? req.wdata : cnt0_pre_q;
  assign pre1_src = wr1_pre ? req.wdata : cnt1_pre_q;

  tecfd_counter #(.WIDTH(DATA_W), .HAS_PSC(1'b1)) u_cnt0 (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .ctrl       (cnt0_ctrl_q),
    .preload    (pre0_src),
    .preload_wr (wr0_pre),
    .inhibit    (inh0),
    .ext_pin    (ext_pin0),
    .count_q    (cnt0_val),
    .ovf        (ovf0),
    .run_clear  (clr0)
  );

  // No prescaler on counter 1
  tecfd_counter #(.WIDTH(DATA_W), .HAS_PSC(1'b0)) u_cnt1 (  // [RL9]
    .core_clk   (core_clk),
    .rstn       (rstn),
    .ctrl       (cnt1_ctrl_q),
    .preload    (pre1_src),
    .preload_wr (wr1_pre),
    .inhibit    (inh1),
    .ext_pin    (ext_pin1),
    .count_q    (cnt1_val),
    .ovf        (ovf1),
    .run_clear  (clr1)
  );

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt0_ctrl_q <= 8'h00;
    end else if (req.wr && req.addr == ADDR_CNT0_CTRL) begin
      cnt0_ctrl_q <= req.wdata;  // [RL21] [RL18]
    end else if (clr0) begin
      cnt0_ctrl_q[CTL_RUN] <= 1'b0;  // [RL23]
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt1_ctrl_q <= 8'h00;
    end else if (req.wr && req.addr == ADDR_CNT1_CTRL) begin
      cnt1_ctrl_q <= req.wdata;
    end else if (clr1) begin
      cnt1_ctrl_q[CTL_RUN] <= 1'b0;  // [RL23]
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt0_pre_q <= 8'h00;
      cnt1_pre_q <= 8'h00;
    end else begin
      if (wr0_pre) begin
        cnt0_pre_q <= req.wdata;
      end
      if (wr1_pre) begin
        cnt1_pre_q <= req.wdata;
      end
    end
  end

  // Overflow sets the flag even while a write clears it
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      irq_ctrl_q <= 8'h00;
    end else begin
      if (req.wr && req.addr == ADDR_IRQ_CTRL) begin
        irq_ctrl_q <= req.wdata;
      end
      if (ovf0) begin
        irq_ctrl_q[IRQ_FLAG0] <= 1'b1;  // [RL15]
      end
      if (ovf1) begin
        irq_ctrl_q[IRQ_FLAG1] <= 1'b1;  // [RL15]
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      misc_q      <= 8'h00;
      port_dir_q  <= 8'hff;
      port_data_q <= 8'h00;
      pwr_down_q  <= 1'b0;
    end else if (req.wr) begin
      unique case (req.addr)
        ADDR_MISC_CTRL: misc_q      <= req.wdata;
        ADDR_PORT_DIR:  port_dir_q  <= req.wdata;
        ADDR_PORT_DATA: port_data_q <= req.wdata;
        ADDR_PWR_CTRL:  pwr_down_q  <= req.wdata[0];
        default:        ;
      endcase
    end
  end

  assign sel_ovf = misc_q[MISC_DIV_SEL] ? ovf1 : ovf0;  // [RL5]

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tone_q <= 1'b0;
    end else if (misc_q[MISC_DIV_EN] && sel_ovf) begin
      tone_q <= ~tone_q;  // [RL4]
    end
  end

  // Direction bit high means input
  assign div_on_pin = misc_q[MISC_DIV_EN] && !port_dir_q[DIV_PIN_BIT];  // [RL6]

  always_comb begin
    port_oe  = ~port_dir_q;  // [RL10]
    port_out = port_data_q;
    if (div_on_pin) begin
      port_out[DIV_PIN_BIT] = port_data_q[DIV_PIN_BIT] & tone_q;  // [RL7]
    end
  end

  // Flags are set in timer, event and pulse mode alike; only the enable bit decides delivery
  assign irq0 = irq_ctrl_q[IRQ_FLAG0] && irq_ctrl_q[IRQ_EN0];  // [RL15] [RL16]
  assign irq1 = irq_ctrl_q[IRQ_FLAG1] && irq_ctrl_q[IRQ_EN1];  // [RL16]

  always_comb begin
    evt.irq_req    = irq0 || irq1;  // [RL12]
    evt.irq_vector = irq0 ? VECTOR_CNT0 : VECTOR_CNT1;  // [RL13]
    // A flag already set masks the wake, as software intends
    evt.wake = pwr_down_q && ((ovf0 && !irq_ctrl_q[IRQ_FLAG0])
                           || (ovf1 && !irq_ctrl_q[IRQ_FLAG1]));  // [RL19] [RL20]
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        ADDR_CNT0_CTRL: rdata <= cnt0_ctrl_q;
        ADDR_CNT0_PRE:  rdata <= cnt0_pre_q;
        ADDR_CNT0_VAL:  rdata <= cnt0_val;
        ADDR_CNT1_CTRL: rdata <= cnt1_ctrl_q;
        ADDR_CNT1_PRE:  rdata <= cnt1_pre_q;
        ADDR_CNT1_VAL:  rdata <= cnt1_val;
        ADDR_IRQ_CTRL:  rdata <= irq_ctrl_q;
        ADDR_MISC_CTRL: rdata <= misc_q;
        ADDR_PORT_DIR:  rdata <= port_dir_q;
        ADDR_PORT_DATA: rdata <= port_in;
        ADDR_PWR_CTRL:  rdata <= {7'h00, pwr_down_q};
        default:        rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule : tecfd_top

/* File: tb/tecfd_chk_sva.sv */
`timescale 1ns/10ps
module tecfd_chk
  import tecfd_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  rstn,
  input wire tecfd_pkg::tecfd_req_t req,
  input wire logic [7:0]            rdata,
  input wire logic [7:0]            port_out,
  input wire logic [7:0]            port_oe,
  input wire tecfd_pkg::tecfd_evt_t evt
);
  logic [7:0] dir_q, dat_q, irq_q;
  logic       div_q, pd_q;
  // Software-owned bits only; hardware flags stay unmodelled
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dir_q <= 8'hff;
      dat_q <= 8'h00;
      irq_q <= 8'h00;
      div_q <= 1'b0;
      pd_q  <= 1'b0;
    end else if (req.wr) begin
      if (req.addr == ADDR_PORT_DIR) dir_q <= req.wdata;
      if (req.addr == ADDR_PORT_DATA) dat_q <= req.wdata;
      if (req.addr == ADDR_IRQ_CTRL) irq_q <= req.wdata;
      if (req.addr == ADDR_MISC_CTRL) div_q <= req.wdata[MISC_DIV_EN];
      if (req.addr == ADDR_PWR_CTRL) pd_q <= req.wdata[0];
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle_zero: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_unmapped_read: assert property (req.rd && req.addr > ADDR_PWR_CTRL |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_dir_readback: assert property (req.rd && req.addr == ADDR_PORT_DIR |=> rdata == $past(dir_q))
    else $error("direction readback wrong");
  a_oe_from_dir: assert property (port_oe == ~dir_q)
    else $error("output enable does not follow direction");
  a_plain_port: assert property (port_out[7:2] == dat_q[7:2] && port_out[0] == dat_q[0])
    else $error("plain port bits wrong");
  a_gate_low: assert property (!dat_q[DIV_PIN_BIT] |-> !port_out[DIV_PIN_BIT])
    else $error("divider pin not held low");
  a_div_off_io: assert property (!div_q |-> port_out[DIV_PIN_BIT] == dat_q[DIV_PIN_BIT])
    else $error("shared pin not plain output");
  a_no_irq_masked: assert property (!irq_q[IRQ_EN0] && !irq_q[IRQ_EN1] |-> !evt.irq_req)
    else $error("interrupt while disabled");
  a_vector_cnt0: assert property (evt.irq_req && !irq_q[IRQ_EN1] |-> evt.irq_vector == 8'h08)
    else $error("counter 0 vector wrong");
  a_wake_in_pd: assert property (evt.wake |-> pd_q || $past(pd_q))
    else $error("wake outside power-down");
endmodule : tecfd_chk

/* File: tb/tecfd_pin_src.sv */
`timescale 1ns/10ps
module tecfd_pin_src (
  input  wire logic core_clk,
  output logic      pin0,
  output logic      pin1
);
  // Idle high: pull-high stays on while the pin feeds a counter
  initial begin
    pin0 = 1'b1;
    pin1 = 1'b1;
  end
  // Low pulse of width cycles; seen by the counter one tick later
  task automatic pulse(input int idx, input int width);
    @(posedge core_clk);
    if (idx == 0) pin0 <= 1'b0; else pin1 <= 1'b0;
    repeat (width) @(posedge core_clk);
    if (idx == 0) pin0 <= 1'b1; else pin1 <= 1'b1;
  endtask : pulse
endmodule : tecfd_pin_src

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import tecfd_pkg::*;
  logic       core_clk, rstn, ext_pin0, ext_pin1;
  tecfd_req_t req;
  tecfd_evt_t evt;
  logic [7:0] rdata, port_in, port_out, port_oe, v, pre;
  int         miscompares, n_compared, seed, t, w;
  tecfd_top dut (.core_clk(core_clk), .rstn(rstn), .req(req), .rdata(rdata),
    .ext_pin0(ext_pin0), .ext_pin1(ext_pin1), .port_in(port_in), .port_out(port_out),
    .port_oe(port_oe), .evt(evt));
  tecfd_pin_src src (.core_clk(core_clk), .pin0(ext_pin0), .pin1(ext_pin1));
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic end_of_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req <= '0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req <= '0;
    #1 d = rdata;
    @(posedge core_clk);
  endtask : rd
  // Cycles between two divider toggles, no bus traffic in between
  task automatic period(output int p);
    logic l;
    int   n, f;
    f = 0;
    #1 l = port_out[1];
    for (n = 1; n < 20000; n++) begin
      @(posedge core_clk);
      #1;
      if (port_out[1] !== l) begin
        l = port_out[1];
        if (f == 0) f = n; else break;
      end
    end
    p = n - f;
    if (n >= 20000) begin chk("toggle wait", 1, 0); end_of_test(); end
    @(posedge core_clk);
  endtask : period
  // Cycles out of 100 in which the shared pin differs from lv
  task automatic level_runs(input logic lv, output int c);
    c = 0;
    repeat (100) begin
      @(posedge core_clk);
      #1 c += (port_out[DIV_PIN_BIT] !== lv);
    end
  endtask : level_runs
  // Leaves the caller 1 ns after the edge where the event shows
  task automatic wait_evt(input bit wk);
    int n;
    #1;
    for (n = 0; n < 2000 && (wk ? evt.wake : evt.irq_req) !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    if (n >= 2000) begin chk("event wait", 1, 0); end_of_test(); end
  endtask : wait_evt
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    seed = 32'hdcf6;
    miscompares = 0;
    n_compared = 0;
    rstn = 1'b0;
    req = '0;
    port_in = 8'h00;
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    port_in <= 8'($random(seed));
    @(posedge core_clk);
    rd(ADDR_PORT_DIR, v); chk("dir reset", 8'hff, v);
    rd(ADDR_IRQ_CTRL, v); chk("irq reset", 8'h00, v);
    rd(ADDR_PORT_DATA, v); chk("pin levels", port_in, v);
    wr(4'hc, 8'($random(seed)));
    rd(4'hc, v); chk("unmapped", 8'h00, v);
    $display("test registers done");
    wr(ADDR_PORT_DIR, 8'hfd); wr(ADDR_PORT_DATA, 8'h02); wr(ADDR_MISC_CTRL, 8'h01);
    for (int p = 0; p < 8; p++) begin
      pre = (p == 0) ? 8'hff : 8'he0 | 8'($random(seed) & 31);
      wr(ADDR_CNT0_CTRL, 8'h00); wr(ADDR_CNT0_PRE, pre); wr(ADDR_CNT0_CTRL, 8'h90 | 8'(p));
      period(t); chk("cnt0 period", (256 - pre) << p, t);
    end
    wr(ADDR_CNT0_CTRL, 8'h00); wr(ADDR_MISC_CTRL, 8'h03);
    pre = 8'he0 | 8'($random(seed) & 31);
    wr(ADDR_CNT1_PRE, pre); wr(ADDR_CNT1_CTRL, 8'h97);
    period(t); chk("cnt1 period", 256 - pre, t);
    wr(ADDR_PORT_DATA, 8'h00);
    level_runs(1'b0, w); chk("pin gated low", 0, w);
    wr(ADDR_PORT_DATA, 8'h02); wr(ADDR_PORT_DIR, 8'hff);
    level_runs(1'b1, w); chk("pin as input", 0, w);
    $display("test timer done");
    wr(ADDR_IRQ_CTRL, 8'h00);
    repeat (300) @(posedge core_clk);
    rd(ADDR_IRQ_CTRL, v); chk("flag1 masked", 1, v[IRQ_FLAG1]);
    wr(ADDR_IRQ_CTRL, 8'h08); wait_evt(0);
    chk("vector1", VECTOR_CNT1, evt.irq_vector);
    @(posedge core_clk);
    wr(ADDR_CNT1_CTRL, 8'h00); wr(ADDR_IRQ_CTRL, 8'h00);
    wr(ADDR_CNT0_PRE, 8'hf0); wr(ADDR_CNT0_CTRL, 8'h90); wr(ADDR_IRQ_CTRL, 8'h04);
    wait_evt(0); chk("vector0", 8'h08, evt.irq_vector);
    @(posedge core_clk);
    wr(ADDR_CNT0_CTRL, 8'h00); wr(ADDR_PWR_CTRL, 8'h01); wr(ADDR_IRQ_CTRL, 8'h00);
    wr(ADDR_CNT0_CTRL, 8'h90);
    wait_evt(1); chk("wake", 1, evt.wake);
    w = 0;
    repeat (200) begin
      @(posedge core_clk);
      #1 w += (evt.wake === 1'b1);
    end
    chk("wake with flag set", 0, w);
    @(posedge core_clk);
    wr(ADDR_PWR_CTRL, 8'h00); wr(ADDR_CNT0_CTRL, 8'h00);
    $display("test interrupt done");
    for (int e = 0; e < 2; e++) begin
      wr(ADDR_CNT1_CTRL, 8'h00); wr(ADDR_IRQ_CTRL, 8'h00); wr(ADDR_CNT1_PRE, 8'hfd);
      wr(ADDR_CNT1_CTRL, 8'h50 | 8'(e << 3));
      repeat (4) begin
        src.pulse(1, 1 + ($random(seed) & 3));
        repeat (2) @(posedge core_clk);
      end
      rd(ADDR_CNT1_VAL, v); chk("event count", 8'hfe, v);
      rd(ADDR_IRQ_CTRL, v); chk("event flag", 1, v[IRQ_FLAG1]);
    end
    wr(ADDR_CNT1_CTRL, 8'h00); wr(ADDR_CNT0_PRE, 8'h10); wr(ADDR_CNT0_CTRL, 8'hd0);
    w = 20 + ($random(seed) & 31);
    src.pulse(0, w);
    repeat (4) @(posedge core_clk);
    rd(ADDR_CNT0_VAL, pre);
    chk("pulse width", 1, pre >= 8'(14 + w) && pre <= 8'(18 + w));
    rd(ADDR_CNT0_CTRL, v); chk("run cleared", 0, v[CTL_RUN]);
    src.pulse(0, 10);
    repeat (4) @(posedge core_clk);
    rd(ADDR_CNT0_VAL, v); chk("pulse ignored", pre, v);
    $display("test pin modes done");
    end_of_test();
  end
endmodule : testbench

bind tecfd_top tecfd_chk chk_i (.core_clk(core_clk), .rstn(rstn), .req(req), .rdata(rdata),
  .port_out(port_out), .port_oe(port_oe), .evt(evt));
